//--- hdl/codec_ctrl_defs.svh
/*
 * Register offsets, reset values and volume link codes of the codec control bank.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CODEC_CTRL_DEFS_SVH
`define CODEC_CTRL_DEFS_SVH

// ********************************************************************
// Offsets
// ********************************************************************
`define OFS_POWER        8'h05
`define OFS_AUDIO3       8'h06
`define OFS_BASS0        8'h07

// ********************************************************************
// Reset values
// ********************************************************************
`define RST_POWER_CTRL   10'h3ff
`define RST_DONE_FLAGS   4'hf
`define RST_BASS0        16'h6be3
`define REVISION_DEFAULT 3'h1

// ********************************************************************
// Volume link codes
// ********************************************************************
`define VOL_LEFT_FOLLOWS  2'h1
`define VOL_RIGHT_FOLLOWS 2'h2

`endif

//--- hdl/codec_ctrl_pkg.sv
/*
 * Types for the codec control bank.
 * Assumes nothing of its surroundings.
 */
package codec_ctrl_pkg;

  typedef struct packed {
    logic handset_bias_off;
    logic headset_bias_off;
    logic sidetone_off;
    logic speaker_one_off;
    logic speaker_two_off;
    logic playback_conv_off;
    logic record_conv_off;
    logic virtual_ground_off;
    logic cell_out_off;
    logic loudspeaker_off;
  } power_ctrl_type;

  typedef struct packed {
    logic record_off_done;
    logic left_play_off_done;
    logic right_play_off_done;
    logic sidetone_off_done;
  } off_done_type;

  typedef struct packed {
    logic record_overflow;
    logic left_play_overflow;
    logic right_play_overflow;
  } overflow_type;

  typedef struct packed {
    logic [1:0] volume_link_sel;
    logic       reference_rate_sel;
    logic       transfer_mode_sel;
    logic       master_sel;
    logic       cell_in_diff;
    logic       cell_out_diff;
    logic [1:0] reserved_bits;
    logic       clip_stepping;
  } audio_ctrl_type;

  typedef struct packed {
    power_ctrl_type power;
    off_done_type   done;
    logic           effects_filter_on;
    logic           deemphasis_on;
    audio_ctrl_type audio;
    overflow_type   ovf;
    logic [15:0]    left_bass_coef_zero;
    logic [15:0]    rdata;
    logic           codec_all_off;
    logic           left_vol_from_right;
    logic           right_vol_from_left;
    logic           clip_stepping_active;
  } state_type;

endpackage : codec_ctrl_pkg

//--- hdl/codec_ctrl_regs.sv
/*
 * Codec power control, audio control and first bass-boost coefficient registers.
 * Assumes a single-cycle register port on clk_i; status inputs from analog or
 * other domains arrive asynchronously and are synchronised here.
 */
// The plain strobed port was left to the implementer.
// Function
// [R1] Mic bias bits 15 and 14 power down their sources when one; reset one.
// [R2] Bit 13 powers down sidetone when one; reset one.
// [R3] Bits 12 and 11 power down speaker outputs one and two when one.
// [R4] Bits 10 and 9 power down playback and record converters; reset one.
// [R5] Bits 8 and 7 power down virtual ground and cellular output.
// [R6] Bit 6 powers down loudspeaker driver when one; reset one.
// [R7] All bits 15 to 6 set means whole codec powered down.
// [R8] Read-only bit 5 shows record converter power-down complete; reset one.
// [R9] Read-only bits 4 and 3 show left, right playback power-down done.
// [R10] Read-only bit 2 shows sidetone power-down complete; reset one.
// [R11] Bit 1 enables effects filter; reset zero.
// [R12] Bit 0 enables de-emphasis filter; reset zero.
// [R13] Volume code 01 left follows right, 10 right follows left.
// [R14] Reference rate bit: zero 48.0 kHz, one 44.1 kHz.
// [R15] Transfer mode bit: zero continuous, one 256-s mode.
// [R16] Bit 11 selects master when one, slave when zero; reset slave.
// [R17] Bits 10 and 9 select differential cellular input and output.
// [R18] Read-only bit 8 set when record data exceeded saturation.
// [R19] Read-only bits 7 and 6 set on left, right playback overflow.
// [R20] Overflow flags clear after host reads audio control register.
// [R21] Clip stepping acts only when microphone gain control is selected.
// [R22] Bass coefficient zero is signed 16-bit, reset 27619.
// [R23] Overflow flags stay set until the host reads them.
`timescale 1ns/100ps
`include "codec_ctrl_defs.svh"

module codec_ctrl_regs #(
  parameter logic [2:0] REVISION = `REVISION_DEFAULT  // Arbitrary value
) (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic [7:0]                   addr_i,
  input  wire logic [15:0]                  wdata_i,
  input  wire logic                         write_i,
  input  wire logic                         read_i,
  output logic      [15:0]                  rdata_o,
  input  wire logic [3:0]                   off_done_i,
  input  wire logic [2:0]                   overflow_i,
  input  wire logic                         agc_selected_i,
  output codec_ctrl_pkg::power_ctrl_type    power_off_o,
  output logic                              codec_all_off_o,
  output logic                              effects_filter_on_o,
  output logic                              deemphasis_on_o,
  output logic                              left_vol_from_right_o,
  output logic                              right_vol_from_left_o,
  output logic                              reference_rate_sel_o,
  output logic                              transfer_mode_sel_o,
  output logic                              master_sel_o,
  output logic                              cell_in_diff_o,
  output logic                              cell_out_diff_o,
  output logic                              clip_stepping_active_o,
  output logic      [15:0]                  left_bass_coef_zero_o
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  logic [3:0] done_meta;
  logic [3:0] done_sync;
  logic [2:0] ovf_meta;
  logic [2:0] ovf_sync;
  logic       agc_meta;
  logic       agc_sync;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_meta <= `RST_DONE_FLAGS;
      done_sync <= `RST_DONE_FLAGS;
      ovf_meta  <= 3'h0;
      ovf_sync  <= 3'h0;
      agc_meta  <= 1'h0;
      agc_sync  <= 1'h0;
    end else begin
      done_meta <= off_done_i;
      done_sync <= done_meta;
      ovf_meta  <= overflow_i;
      ovf_sync  <= ovf_meta;
      agc_meta  <= agc_selected_i;
      agc_sync  <= agc_meta;
    end
  end

  // ********************************************************************
  // Register state
  // ********************************************************************
  codec_ctrl_pkg::state_type state;
  codec_ctrl_pkg::state_type next_state;

  logic wr_power;
  logic wr_audio;
  logic wr_bass;
  logic rd_audio;

  assign wr_power = write_i && (addr_i == `OFS_POWER);
  assign wr_audio = write_i && (addr_i == `OFS_AUDIO3);
  assign wr_bass  = write_i && (addr_i == `OFS_BASS0);
  assign rd_audio = read_i && (addr_i == `OFS_AUDIO3);

  always_comb begin
    next_state = state;
    if (wr_power) begin
      next_state.power             = codec_ctrl_pkg::power_ctrl_type'(wdata_i[15:6]); // R1 R2 R3 R4 R5 R6
      next_state.effects_filter_on = wdata_i[1]; // R11
      next_state.deemphasis_on     = wdata_i[0]; // R12
    end
    if (wr_audio) begin
      next_state.audio.volume_link_sel    = wdata_i[15:14]; // R13
      next_state.audio.reference_rate_sel = wdata_i[13];    // R14
      next_state.audio.transfer_mode_sel  = wdata_i[12];    // R15
      next_state.audio.master_sel         = wdata_i[11];    // R16
      next_state.audio.cell_in_diff       = wdata_i[10];    // R17
      next_state.audio.cell_out_diff      = wdata_i[9];     // R17
      next_state.audio.reserved_bits      = wdata_i[5:4];
      next_state.audio.clip_stepping      = wdata_i[3];
    end
    if (wr_bass) begin
      next_state.left_bass_coef_zero = wdata_i; // R22
    end
    next_state.done = codec_ctrl_pkg::off_done_type'(done_sync); // R8 R9 R10
    // Read clears flags; a new overflow in the same cycle still sets
    if (rd_audio) begin
      next_state.ovf = codec_ctrl_pkg::overflow_type'(3'h0); // R20
    end
    next_state.ovf = codec_ctrl_pkg::overflow_type'(next_state.ovf | ovf_sync); // R18 R19 R23
    next_state.codec_all_off        = &next_state.power; // R7
    next_state.left_vol_from_right  = next_state.audio.volume_link_sel == `VOL_LEFT_FOLLOWS;  // R13
    next_state.right_vol_from_left  = next_state.audio.volume_link_sel == `VOL_RIGHT_FOLLOWS; // R13
    next_state.clip_stepping_active = next_state.audio.clip_stepping & agc_sync; // R21
    next_state.rdata = 16'h0000;
    if (read_i) begin
      case (addr_i)
        `OFS_POWER: begin
          next_state.rdata = {state.power, state.done, state.effects_filter_on, state.deemphasis_on};
        end
        `OFS_AUDIO3: begin
          next_state.rdata = {state.audio.volume_link_sel, state.audio.reference_rate_sel,
                              state.audio.transfer_mode_sel, state.audio.master_sel,
                              state.audio.cell_in_diff, state.audio.cell_out_diff, state.ovf,
                              state.audio.reserved_bits, state.audio.clip_stepping, REVISION};
        end
        `OFS_BASS0: begin
          next_state.rdata = state.left_bass_coef_zero;
        end
        default: begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state                      <= '0;
      state.power                <= codec_ctrl_pkg::power_ctrl_type'(`RST_POWER_CTRL);
      state.done                 <= codec_ctrl_pkg::off_done_type'(`RST_DONE_FLAGS);
      state.left_bass_coef_zero  <= `RST_BASS0;
      state.codec_all_off        <= 1'h1;
    end else begin
      state <= next_state;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign rdata_o                = state.rdata;
  assign power_off_o            = state.power;
  assign codec_all_off_o        = state.codec_all_off;
  assign effects_filter_on_o    = state.effects_filter_on;
  assign deemphasis_on_o        = state.deemphasis_on;
  assign left_vol_from_right_o  = state.left_vol_from_right;
  assign right_vol_from_left_o  = state.right_vol_from_left;
  assign reference_rate_sel_o   = state.audio.reference_rate_sel;
  assign transfer_mode_sel_o    = state.audio.transfer_mode_sel;
  assign master_sel_o           = state.audio.master_sel;
  assign cell_in_diff_o         = state.audio.cell_in_diff;
  assign cell_out_diff_o        = state.audio.cell_out_diff;
  assign clip_stepping_active_o = state.clip_stepping_active;
  assign left_bass_coef_zero_o  = state.left_bass_coef_zero;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence s_power_write;
    wr_power;
  endsequence

  sequence s_audio_read;
    rd_audio;
  endsequence

  sequence s_quiet_ovf;
    ovf_sync == 3'h0;
  endsequence

  sequence s_audio_write;
    wr_audio;
  endsequence

  sequence s_power_read;
    read_i && addr_i == `OFS_POWER;
  endsequence

  sequence s_bass_read;
    read_i && addr_i == `OFS_BASS0;
  endsequence

  sequence s_unmapped_read;
    read_i && addr_i != `OFS_POWER && addr_i != `OFS_AUDIO3 && addr_i != `OFS_BASS0;
  endsequence

  sequence s_no_read;
    !read_i;
  endsequence

  sequence s_ovf_event;
    ovf_sync != 3'h0;
  endsequence

  sequence s_agc_on;
    agc_sync;
  endsequence

  sequence s_clip_kept;
    state.audio.clip_stepping && !wr_audio;
  endsequence

  sequence s_all_off_data;
    wdata_i[15:6] == 10'h3ff;
  endsequence

  AST_POWER_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R1
    s_power_write |=> power_off_o == $past(wdata_i[15:6]))
    else $error("power-down bits not taken from write");

  AST_ALL_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
    codec_all_off_o == (&power_off_o))
    else $error("codec all-off flag mismatches power bits");

  AST_DONE_FOLLOWS: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
    ##3 state.done == $past(off_done_i, 3))
    else $error("power-down done flags not three cycles behind input");

  AST_EFFECTS: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
    wr_power |=> effects_filter_on_o == $past(wdata_i[1]) && deemphasis_on_o == $past(wdata_i[0]))
    else $error("filter enables not taken from write");

  AST_VOL_LINK: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
    !(left_vol_from_right_o && right_vol_from_left_o))
    else $error("both volume link directions active");

  AST_MASTER: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
    wr_audio |=> master_sel_o == $past(wdata_i[11]))
    else $error("master select not taken from write");

  AST_OVF_STICKY: assert property (@(posedge clk_i) disable iff (!resetn_i) // R23
    state.ovf[2] && !rd_audio |=> state.ovf[2])
    else $error("overflow flag lost without a read");

  AST_OVF_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i) // R20
    s_audio_read and s_quiet_ovf |=> state.ovf == 3'h0)
    else $error("overflow flags not cleared by read");

  AST_CLIP_GATED: assert property (@(posedge clk_i) disable iff (!resetn_i) // R21
    clip_stepping_active_o |-> $past(agc_sync))
    else $error("clip stepping active without gain control");

  AST_BASS_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R22
    wr_bass |=> left_bass_coef_zero_o == $past(wdata_i))
    else $error("bass coefficient not taken from write");

  AST_SIDETONE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R2
    s_power_write |=> power_off_o.sidetone_off == $past(wdata_i[13]))
    else $error("sidetone bit not taken from write");

  AST_SPEAKERS: assert property (@(posedge clk_i) disable iff (!resetn_i) // R3
    s_power_write |=> {power_off_o.speaker_one_off, power_off_o.speaker_two_off} == $past(wdata_i[12:11]))
    else $error("speaker bits not taken from write");

  AST_CONVERTERS: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
    s_power_write |=> {power_off_o.playback_conv_off, power_off_o.record_conv_off} == $past(wdata_i[10:9]))
    else $error("converter bits not taken from write");

  AST_GROUND_CELL: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
    s_power_write |=> {power_off_o.virtual_ground_off, power_off_o.cell_out_off} == $past(wdata_i[8:7]))
    else $error("ground or cell bits not taken from write");

  AST_LOUDSPEAKER: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
    s_power_write |=> power_off_o.loudspeaker_off == $past(wdata_i[6]))
    else $error("loudspeaker bit not taken from write");

  AST_POWER_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i) // R1
    !wr_power |=> $stable(power_off_o))
    else $error("power bits changed without a write");

  AST_ALL_OFF_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
    s_power_write and s_all_off_data |=> codec_all_off_o)
    else $error("all-off flag low after all bits set");

  AST_DONE_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
    s_power_write |=> state.done == $past(done_sync))
    else $error("done flags changed by a write");

  AST_DONE_READ: assert property (@(posedge clk_i) disable iff (!resetn_i) // R9
    s_power_read |=> rdata_o[5:2] == $past(state.done))
    else $error("done flags misread");

  AST_SIDETONE_DONE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R10
    s_power_read |=> rdata_o[2] == $past(state.done.sidetone_off_done))
    else $error("sidetone done flag misread");

  AST_POWER_READ: assert property (@(posedge clk_i) disable iff (!resetn_i) // R1
    s_power_read |=> rdata_o[15:6] == $past(power_off_o))
    else $error("power bits misread");

  AST_FILTER_READ: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
    s_power_read |=> rdata_o[1:0] == $past({effects_filter_on_o, deemphasis_on_o}))
    else $error("filter enables misread");

  AST_FILTER_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
    !wr_power |=> $stable(effects_filter_on_o) && $stable(deemphasis_on_o))
    else $error("filter enables changed without a write");

  AST_VOL_LEFT: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
    s_audio_write |=> left_vol_from_right_o == ($past(wdata_i[15:14]) == `VOL_LEFT_FOLLOWS))
    else $error("left volume link wrong");

  AST_VOL_RIGHT: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
    s_audio_write |=> right_vol_from_left_o == ($past(wdata_i[15:14]) == `VOL_RIGHT_FOLLOWS))
    else $error("right volume link wrong");

  AST_RATE: assert property (@(posedge clk_i) disable iff (!resetn_i) // R14
    s_audio_write |=> reference_rate_sel_o == $past(wdata_i[13]))
    else $error("rate select not taken from write");

  AST_XFER: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
    s_audio_write |=> transfer_mode_sel_o == $past(wdata_i[12]))
    else $error("transfer mode not taken from write");

  AST_CELL_DIFF: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
    s_audio_write |=> {cell_in_diff_o, cell_out_diff_o} == $past(wdata_i[10:9]))
    else $error("cellular modes not taken from write");

  AST_AUDIO_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
    !wr_audio |=> $stable(master_sel_o) && $stable(reference_rate_sel_o))
    else $error("audio control changed without a write");

  AST_AUDIO_READ: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
    s_audio_read |=> rdata_o[11] == $past(master_sel_o))
    else $error("master select misread");

  AST_OVF_SET: assert property (@(posedge clk_i) disable iff (!resetn_i) // R18
    s_ovf_event |=> (state.ovf & $past(ovf_sync)) == $past(ovf_sync))
    else $error("overflow event not flagged");

  AST_OVF_READ: assert property (@(posedge clk_i) disable iff (!resetn_i) // R19
    s_audio_read |=> rdata_o[8:6] == $past(state.ovf))
    else $error("overflow flags misread");

  AST_CLIP_FOLLOWS: assert property (@(posedge clk_i) disable iff (!resetn_i) // R21
    s_agc_on and s_clip_kept |=> clip_stepping_active_o)
    else $error("clip stepping inactive with gain control");

  AST_BASS_READ: assert property (@(posedge clk_i) disable iff (!resetn_i) // R22
    s_bass_read |=> rdata_o == $past(left_bass_coef_zero_o))
    else $error("bass coefficient misread");

  AST_BASS_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i) // R22
    !wr_bass |=> $stable(left_bass_coef_zero_o))
    else $error("bass coefficient changed without a write");

  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_no_read |=> rdata_o == 16'h0000)
    else $error("read data not zero after idle cycle");

  AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_unmapped_read |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");

endmodule : codec_ctrl_regs

//--- verif/codec_power_and_audio_control_regs_tb.sv
/*
 * Self-checking bench for the codec control register bank.
 * Assumes the register port of codec_ctrl_regs and a 20 MHz clock.
 */
`timescale 1ns/100ps
`include "codec_ctrl_defs.svh"

module codec_power_and_audio_control_regs_tb;
  // ********************************************************************
  // Signals
  // ********************************************************************
  localparam logic [2:0] REV = 3'h5;  // Arbitrary value
  logic                           clk_i = 1'b0;
  logic                           resetn_i = 1'b0;
  logic [7:0]                     addr_i = 8'h00;
  logic [15:0]                    wdata_i = 16'h0000;
  logic                           write_i = 1'b0;
  logic                           read_i = 1'b0;
  logic [15:0]                    rdata_o;
  logic [3:0]                     off_done_i = 4'hf;
  logic [2:0]                     overflow_i = 3'h0;
  logic                           agc_selected_i = 1'b0;
  codec_ctrl_pkg::power_ctrl_type power_off_o;
  logic                           codec_all_off_o, effects_filter_on_o, deemphasis_on_o;
  logic                           left_vol_from_right_o, right_vol_from_left_o;
  logic                           reference_rate_sel_o, transfer_mode_sel_o, master_sel_o;
  logic                           cell_in_diff_o, cell_out_diff_o, clip_stepping_active_o;
  logic [15:0]                    left_bass_coef_zero_o;
  logic [15:0]                    rd_val;
  int                             n_fail = 0;
  int                             compares = 0;
  int                             cycles = 0;

  always #25 clk_i = ~clk_i;

  codec_ctrl_regs #(.REVISION(REV)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .off_done_i(off_done_i),
    .overflow_i(overflow_i), .agc_selected_i(agc_selected_i), .power_off_o(power_off_o),
    .codec_all_off_o(codec_all_off_o), .effects_filter_on_o(effects_filter_on_o),
    .deemphasis_on_o(deemphasis_on_o), .left_vol_from_right_o(left_vol_from_right_o),
    .right_vol_from_left_o(right_vol_from_left_o), .reference_rate_sel_o(reference_rate_sel_o),
    .transfer_mode_sel_o(transfer_mode_sel_o), .master_sel_o(master_sel_o),
    .cell_in_diff_o(cell_in_diff_o), .cell_out_diff_o(cell_out_diff_o),
    .clip_stepping_active_o(clip_stepping_active_o), .left_bass_coef_zero_o(left_bass_coef_zero_o)
  );

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic test_done;
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask : rd

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset;
    chk_word("power_off", 16'h03ff, {6'h0, power_off_o});
    chk_word("all_off", 16'h0001, {15'h0, codec_all_off_o});
    chk_word("coef", 16'h6be3, left_bass_coef_zero_o);
    rd(8'h05);
    chk_word("reg05", 16'hfffc, rd_val);
    rd(8'h06);
    chk_word("reg06", {13'h0, REV}, rd_val);
    rd(8'h07);
    chk_word("reg07", 16'h6be3, rd_val);
  endtask : t_reset

  task automatic t_power;
    for (int i = 0; i < 10; i++) begin
      wr(8'h05, 16'hffc0 & ~(16'h0040 << i));
      chk_word("power_bit", 16'h03ff & ~(16'h0001 << i), {6'h0, power_off_o});
      chk_word("all_off_bit", 16'h0000, {15'h0, codec_all_off_o});
    end
    wr(8'h05, 16'hffc3);
    chk_word("all_on_filters", 16'h0007, {13'h0, codec_all_off_o, effects_filter_on_o, deemphasis_on_o});
    @(posedge clk_i);
    off_done_i <= 4'b0110;
    wr(8'h05, 16'h003c);
    chk_word("power_clear", 16'h0000, {power_off_o, 3'h0, codec_all_off_o, effects_filter_on_o, deemphasis_on_o});
    repeat (3) @(posedge clk_i);
    rd(8'h05);
    chk_word("done_flags", 16'h0018, rd_val);
    @(posedge clk_i);
    off_done_i <= 4'b1001;
    repeat (4) @(posedge clk_i);
    rd(8'h05);
    chk_word("done_flags2", 16'h0024, rd_val);
  endtask : t_power

  task automatic t_audio;
    wr(8'h06, 16'hffff);
    chk_word("vol_11", 16'h0000, {14'h0, left_vol_from_right_o, right_vol_from_left_o});
    rd(8'h06);
    chk_word("reg06_rw", {13'h1fc7, REV}, rd_val);
    for (int c = 0; c < 3; c++) begin
      wr(8'h06, 16'(c) << 14);
      chk_word("vol_code", 16'(c), {14'h0, right_vol_from_left_o, left_vol_from_right_o});
    end
    for (int i = 9; i < 14; i++) begin
      wr(8'h06, 16'h0001 << i);
      chk_word("audio_bit", 16'h0001 << (i - 9), {11'h0, reference_rate_sel_o, transfer_mode_sel_o,
               master_sel_o, cell_in_diff_o, cell_out_diff_o});
    end
  endtask : t_audio

  task automatic t_clip;
    wr(8'h06, 16'h0008);
    repeat (3) @(posedge clk_i);
    chk_word("clip_no_agc", 16'h0000, {15'h0, clip_stepping_active_o});
    agc_selected_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_word("clip_agc", 16'h0001, {15'h0, clip_stepping_active_o});
    wr(8'h06, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk_word("clip_off", 16'h0000, {15'h0, clip_stepping_active_o});
    agc_selected_i <= 1'b0;
  endtask : t_clip

  task automatic t_overflow;
    @(posedge clk_i);
    overflow_i <= 3'b101;
    @(posedge clk_i);
    overflow_i <= 3'b000;
    repeat (5) @(posedge clk_i);
    rd(8'h06);
    chk_word("ovf_held", {7'h0, 3'b101, 3'h0, REV}, rd_val);
    rd(8'h06);
    chk_word("ovf_cleared", {13'h0, REV}, rd_val);
    @(posedge clk_i);
    overflow_i <= 3'b010;
    repeat (5) @(posedge clk_i);
    overflow_i <= 3'b000;
    rd(8'h06);
    chk_word("ovf_left", {7'h0, 3'b010, 3'h0, REV}, rd_val);
    // Overflow still in the synchroniser at that read sets the flag again
    rd(8'h06);
    chk_word("ovf_set_wins", {7'h0, 3'b010, 3'h0, REV}, rd_val);
    rd(8'h06);
    chk_word("ovf_left_clr", {13'h0, REV}, rd_val);
  endtask : t_overflow

  task automatic t_coef;
    wr(8'h07, 16'h8001);
    chk_word("coef_out", 16'h8001, left_bass_coef_zero_o);
    wr(8'h08, 16'h1234);
    rd(8'h07);
    chk_word("coef_rd", 16'h8001, rd_val);
    rd(8'h08);
    chk_word("unmapped_rd", 16'h0000, rd_val);
  endtask : t_coef

  // ********************************************************************
  // Main sequence and timeout
  // ********************************************************************
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_reset();
    t_power();
    t_audio();
    t_clip();
    t_overflow();
    t_coef();
    test_done();
  end
endmodule : codec_power_and_audio_control_regs_tb
